/* include/disk_err_pkg.sv */
// Purpose: Shared constants for the disk error register and silo readout.
// Assumes: A 20 MHz reference clock and 12-bit processor words.
// Notes:   Processor bit numbers run from 0 (most significant) to 11.
package disk_err_pkg;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          TIMEOUT_MS      = 200;
  localparam int          TIMEOUT_CYCLES  = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int          TIMER_W         = 23;
  // I/O instruction codes (octal 6610 and 6615).
  localparam logic [11:0] READ_ERROR_IOT  = 12'hD88;
  localparam logic [11:0] READ_SILO_IOT   = 12'hD8D;
  // Function codes in command register bits 9..11.
  localparam logic [2:0]  FN_GET_STATUS   = 3'h2;
  localparam logic [2:0]  FN_SEEK         = 3'h3;
  localparam logic [2:0]  FN_READ_HEADER  = 3'h4;
  localparam logic [2:0]  FN_WRITE_DATA   = 3'h5;
  localparam logic [2:0]  FN_READ_DATA    = 3'h6;
  localparam logic [2:0]  FN_READ_NOCHK   = 3'h7;
  // Error code patterns, bit 0 of the pattern is processor bit 0.
  localparam logic [0:2]  CODE_DATA_LATE  = 3'h1;
  localparam logic [0:2]  CODE_OP_INCOMP  = 3'h2;
  localparam logic [0:2]  CODE_HDR_MISS   = 3'h3;
  localparam logic [0:2]  CODE_DATA_CRC   = 3'h4;
  localparam logic [0:2]  CODE_HDR_CRC    = 3'h6;
  localparam logic [0:2]  CODE_RESET      = 3'h0;
  // Error register field positions.
  localparam int          ERR_CODE_LSB    = 0;
  localparam int          ERR_FAULT_POS   = 10;
  localparam int          ERR_READY_POS   = 11;
  // Silo layout.
  localparam int          SILO_DEPTH      = 6;
  localparam int          SILO_PTR_W      = 3;
  localparam int          HDR_ZERO_FIRST  = 2;
  localparam int          HDR_ZERO_LAST   = 3;
  localparam logic [3:0]  UNDEF_BITS      = 4'h0;
  localparam logic [11:0] WC_RESET        = 12'h000;
endpackage

/* core/disk_err_silo.sv */
// Purpose: Error register, silo readout and word counter of a disk controller.
// Assumes: Command, status and header inputs come from logic on ref_clk.
// Notes:   Drive error and drive ready arrive from cable pins.
//
// How it works
// (R01) Read-error code loads the five-bit error register into the work word.
// (R02) Initialize or command load clears error bits 0..2.
// (R03) Command unfinished after 200 ms sets operation incomplete.
// (R04) CRC failure sets bit 0; header CRC also sets operation incomplete.
// (R05) Write with silo empty and word count nonzero sets data late.
// (R06) Read with silo full and word count nonzero sets data late.
// (R07) Codes: late 001, incomplete 010, no header 011, data 100, header 110.
// (R08) Bit 10 follows the selected drive's error line.
// (R09) Host issues Get Status to find the drive fault's cause.
// (R10) Bit 11 shows drive ready, low from seek start to seek end.
// (R11) Read-silo code moves the next silo word into the work word.
// (R12) After Get Status, first read gives word 1, second gives word 2.
// (R13) Word 1 bits 4..11 hold type, head, lid, heads, brush, phase bits.
// (R14) Word 2 bits 4..11 hold the eight drive fault bits.
// (R15) Read Header stores six header bytes as six 12-bit silo words.
// (R16) Header words: two address words, two zero words, two CRC words.
// (R17) Host loads no register until the controller reports ready.
// (R18) Word counter increments per transfer and ends the command on overflow.
`timescale 1ns/10ps
module disk_err_silo #(
  parameter int TIMEOUT_CYCLES = disk_err_pkg::TIMEOUT_CYCLES,
  parameter int SILO_DEPTH     = disk_err_pkg::SILO_DEPTH
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ctrlInit,
  input  wire logic        cmdLoad,
  input  wire logic [2:0]  cmdFunction,
  input  wire logic        cmdDone,
  input  wire logic        sectorSearch,
  input  wire logic        crcFail,
  input  wire logic        crcInHeader,
  input  wire logic        siloEmpty,
  input  wire logic        siloFull,
  input  wire logic        wcLoad,
  input  wire logic [11:0] wcValue,
  input  wire logic        dmaWord,
  input  wire logic        seekComplete,
  input  wire logic        driveErrorPin,
  input  wire logic        driveReadyPin,
  input  wire logic        statusValid,
  input  wire logic [0:7]  statusWord1,
  input  wire logic [0:7]  statusWord2,
  input  wire logic        headerByteValid,
  input  wire logic [7:0]  headerByte,
  input  wire logic        iotStrobe,
  input  wire logic [11:0] iotCode,
  output logic      [0:11] cpu_work_register,
  output logic             cpuWorkValid,
  output logic      [11:0] wordCount,
  output logic             cmdEnd
);

  typedef enum logic [1:0] {CMD_IDLE, CMD_RUN, CMD_TIMED_OUT} cmd_state_t;

  cmd_state_t                          cmdState_r;
  logic [disk_err_pkg::TIMER_W-1:0]    timer_r;
  logic [0:2]                          errCode_r;
  logic [0:2]                          errCode_nxt;
  logic [2:0]                          function_r;
  logic                                faultMeta_r;
  logic                                drive_fault_flag;
  logic                                readyMeta_r;
  logic                                readySync_r;
  logic                                seekBusy_r;
  logic                                drive_ready_flag;
  logic [0:11]                         silo_r [SILO_DEPTH];
  logic [disk_err_pkg::SILO_PTR_W-1:0] wrPtr_r;
  logic [disk_err_pkg::SILO_PTR_W-1:0] rdPtr_r;
  logic                                timeoutHit;
  logic                                lateHit;
  logic                                readErrIot;
  logic                                readSiloIot;
  logic [0:11]                         errorWord;
  logic [0:11]                         headerWord;

  // Write commands drain the silo; read commands fill it.
  function automatic logic isRead(input logic [2:0] fn);
    return fn == disk_err_pkg::FN_READ_DATA ||
           fn == disk_err_pkg::FN_READ_NOCHK;
  endfunction

  function automatic logic isWrite(input logic [2:0] fn);
    return fn == disk_err_pkg::FN_WRITE_DATA;
  endfunction

  assign readErrIot  = iotStrobe && iotCode == disk_err_pkg::READ_ERROR_IOT;
  assign readSiloIot = iotStrobe && iotCode == disk_err_pkg::READ_SILO_IOT;

  // Drive cable pins pass two flip-flops before use.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      faultMeta_r      <= 1'b0;
      drive_fault_flag <= 1'b0;
      readyMeta_r      <= 1'b0;
      readySync_r      <= 1'b0;
    end else begin
      faultMeta_r      <= driveErrorPin;
      drive_fault_flag <= faultMeta_r; // R08
      readyMeta_r      <= driveReadyPin;
      readySync_r      <= readyMeta_r;
    end
  end

  // Ready is held low between the seek command and seek completion.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seekBusy_r <= 1'b0;
    end else if (ctrlInit) begin
      seekBusy_r <= 1'b0;
    end else if (cmdLoad && cmdFunction == disk_err_pkg::FN_SEEK) begin
      seekBusy_r <= 1'b1; // R10
    end else if (seekComplete) begin
      seekBusy_r <= 1'b0; // R10
    end
  end

  assign drive_ready_flag = readySync_r && !seekBusy_r; // R10

  // Command timer; a fresh load restarts the 200 ms window.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmdState_r <= CMD_IDLE;
      timer_r    <= '0;
      function_r <= 3'h0;
    end else if (ctrlInit) begin
      cmdState_r <= CMD_IDLE;
      timer_r    <= '0;
    end else if (cmdLoad) begin
      cmdState_r <= CMD_RUN;
      timer_r    <= '0;
      function_r <= cmdFunction;
    end else begin
      case (cmdState_r)
        CMD_RUN: begin
          if (cmdDone || cmdEnd) begin
            cmdState_r <= CMD_IDLE;
          end else if (timeoutHit) begin
            cmdState_r <= CMD_TIMED_OUT; // R03
          end else begin
            timer_r <= timer_r + 1'b1;
          end
        end
        CMD_TIMED_OUT: begin
          if (cmdDone) begin
            cmdState_r <= CMD_IDLE;
          end
        end
        default: begin
          timer_r <= '0;
        end
      endcase
    end
  end

  assign timeoutHit = cmdState_r == CMD_RUN && !cmdDone && !cmdEnd &&
                      timer_r == disk_err_pkg::TIMER_W'(TIMEOUT_CYCLES - 1);

  // The late check only bites while a transfer still has words to move.
  assign lateHit = cmdState_r == CMD_RUN && wordCount != 12'h000 &&
                   ((isWrite(function_r) && siloEmpty) ||  // R05
                    (isRead(function_r) && siloFull));      // R06

  // Sets are ORed in after the clear, so an error in the load cycle survives.
  always_comb begin
    errCode_nxt = (ctrlInit || cmdLoad) ? disk_err_pkg::CODE_RESET
                                        : errCode_r; // R02
    if (timeoutHit) begin
      errCode_nxt = errCode_nxt | (sectorSearch ? disk_err_pkg::CODE_HDR_MISS
                                  : disk_err_pkg::CODE_OP_INCOMP); // R03 R07
    end
    if (crcFail) begin
      errCode_nxt = errCode_nxt | (crcInHeader ? disk_err_pkg::CODE_HDR_CRC
                                  : disk_err_pkg::CODE_DATA_CRC); // R04 R07
    end
    if (lateHit) begin
      errCode_nxt = errCode_nxt | disk_err_pkg::CODE_DATA_LATE; // R07
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      errCode_r <= disk_err_pkg::CODE_RESET;
    end else begin
      errCode_r <= errCode_nxt;
    end
  end

  // Word counter holds the two's complement of the transfer length.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wordCount <= disk_err_pkg::WC_RESET;
      cmdEnd    <= 1'b0;
    end else if (ctrlInit) begin
      wordCount <= disk_err_pkg::WC_RESET;
      cmdEnd    <= 1'b0;
    end else if (wcLoad) begin
      wordCount <= wcValue;
      cmdEnd    <= 1'b0;
    end else begin
      cmdEnd <= dmaWord && wordCount == 12'hFFF; // R18
      if (dmaWord) begin
        wordCount <= wordCount + 12'h001; // R18
      end
    end
  end

  // Silo fill: two status words or up to six header bytes per command.
  assign headerWord = (wrPtr_r >= disk_err_pkg::SILO_PTR_W'(
                         disk_err_pkg::HDR_ZERO_FIRST) &&
                       wrPtr_r <= disk_err_pkg::SILO_PTR_W'(
                         disk_err_pkg::HDR_ZERO_LAST))
                      ? 12'h000 : {4'h0, headerByte}; // R15 R16

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_r <= '0;
    end else if (ctrlInit || cmdLoad) begin
      wrPtr_r <= '0;
    end else if (statusValid &&
                 function_r == disk_err_pkg::FN_GET_STATUS) begin
      wrPtr_r <= disk_err_pkg::SILO_PTR_W'(2); // R12
    end else if (headerByteValid &&
                 function_r == disk_err_pkg::FN_READ_HEADER &&
                 wrPtr_r < disk_err_pkg::SILO_PTR_W'(SILO_DEPTH)) begin
      wrPtr_r <= wrPtr_r + 1'b1; // R15
    end
  end

  // Storage has no reset; unread slots are never presented.
  always_ff @(posedge ref_clk) begin
    if (statusValid && function_r == disk_err_pkg::FN_GET_STATUS) begin
      silo_r[0] <= {disk_err_pkg::UNDEF_BITS, statusWord1}; // R12 R13
      silo_r[1] <= {disk_err_pkg::UNDEF_BITS, statusWord2}; // R12 R14
    end else if (headerByteValid &&
                 function_r == disk_err_pkg::FN_READ_HEADER &&
                 wrPtr_r < disk_err_pkg::SILO_PTR_W'(SILO_DEPTH)) begin
      silo_r[wrPtr_r] <= headerWord; // R15
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdPtr_r <= '0;
    end else if (ctrlInit || cmdLoad) begin
      rdPtr_r <= '0;
    end else if (readSiloIot && rdPtr_r < wrPtr_r) begin
      rdPtr_r <= rdPtr_r + 1'b1; // R11
    end
  end

  always_comb begin
    errorWord = 12'h000;
    errorWord[disk_err_pkg::ERR_CODE_LSB +: 3] = errCode_r;
    errorWord[disk_err_pkg::ERR_FAULT_POS] = drive_fault_flag;
    errorWord[disk_err_pkg::ERR_READY_POS] = drive_ready_flag;
  end

  // Reads past the last stored word return zero rather than stale data.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_work_register <= 12'h000;
      cpuWorkValid      <= 1'b0;
    end else begin
      cpuWorkValid <= readErrIot || readSiloIot;
      if (readErrIot) begin
        cpu_work_register <= errorWord; // R01
      end else if (readSiloIot) begin
        cpu_work_register <= (rdPtr_r < wrPtr_r) ?
                             silo_r[rdPtr_r] : 12'h000; // R11
      end
    end
  end

  a_clear_on_load: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cmdLoad || ctrlInit) && !timeoutHit && !crcFail && !lateHit
    |=> errCode_r == disk_err_pkg::CODE_RESET) // R02
    else $error("error code not cleared by load");

  a_timeout_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    timeoutHit && !cmdLoad && !ctrlInit |=> errCode_r[1]) // R03
    else $error("timeout did not set incomplete");

  a_timeout_exact: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmdLoad && !ctrlInit ##1 (cmdState_r == CMD_RUN && !cmdLoad &&
      !cmdDone && !cmdEnd && !ctrlInit)[*4] |-> timer_r == 23'h3) // R03
    else $error("command timer miscounts");

  a_crc_kind: assert property (@(posedge ref_clk) disable iff (!rstn)
    crcFail && crcInHeader |=> errCode_r[0] && errCode_r[1]) // R04
    else $error("header crc code wrong");

  a_late_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmdState_r == CMD_RUN && isWrite(function_r) && siloEmpty &&
    wordCount != 12'h000 |=> errCode_r[2]) // R05
    else $error("write late not flagged");

  a_late_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmdState_r == CMD_RUN && isRead(function_r) && siloFull &&
    wordCount != 12'h000 && !timeoutHit && !crcFail && !cmdLoad &&
    !ctrlInit && errCode_r == 3'h0 |=> errCode_r == 3'h1) // R06 R07
    else $error("read late code wrong");

  a_fault_mirror: assert property (@(posedge ref_clk) disable iff (!rstn)
    readErrIot |=> cpu_work_register[10] == $past(driveErrorPin, 3)) // R08
    else $error("drive fault bit does not follow pin");

  a_seek_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmdLoad && cmdFunction == disk_err_pkg::FN_SEEK && !ctrlInit
    |=> !drive_ready_flag) // R10
    else $error("ready not dropped at seek");

  a_status_order: assert property (@(posedge ref_clk) disable iff (!rstn)
    statusValid && function_r == disk_err_pkg::FN_GET_STATUS && !cmdLoad &&
    !ctrlInit ##1 !(statusValid || cmdLoad || ctrlInit) ##1 readSiloIot &&
    rdPtr_r == '0 |=> cpu_work_register[4:11] == $past(statusWord1, 3)) // R12
    else $error("status word 1 not first");

  a_header_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    readSiloIot && !readErrIot && (rdPtr_r == 3'h2 || rdPtr_r == 3'h3)
    |=> cpu_work_register == 12'h000) // R16
    else $error("header zero words not zero");

  a_wc_overflow: assert property (@(posedge ref_clk) disable iff (!rstn)
    dmaWord && wordCount == 12'hFFF && !wcLoad && !ctrlInit
    |=> cmdEnd && wordCount == 12'h000 ##1 !cmdEnd || dmaWord) // R18
    else $error("overflow did not end command");

  a_error_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    readErrIot |=> cpuWorkValid &&
    cpu_work_register[0:2] == $past(errCode_r) &&
    cpu_work_register[3:9] == 7'h00) // R01
    else $error("error register read wrong");

endmodule

/* tb/drive_model.sv */
// Purpose: Behavioural drive at the far end of the cable.
// Assumes: Tasks are called just after a rising edge of ref_clk.
// Notes:   Idle data lines carry the inverse of the last value sent.
`timescale 1ns/10ps
module drive_model (
  input  wire logic       ref_clk,
  output logic            driveErrorPin,
  output logic            driveReadyPin,
  output logic            statusValid,
  output logic [0:7]      statusWord1,
  output logic [0:7]      statusWord2,
  output logic            headerByteValid,
  output logic [7:0]      headerByte
);
  initial begin
    driveErrorPin = 1'b0;
    driveReadyPin = 1'b1;
    statusValid = 1'b0;
    statusWord1 = 8'h00;
    statusWord2 = 8'hFF;
    headerByteValid = 1'b0;
    headerByte = 8'h00;
  end
  task automatic set_pins(input logic err, input logic rdy);
    driveErrorPin = err;
    driveReadyPin = rdy;
  endtask
  // A gap cycle follows each pulse so that valid is never lowered and
  // raised again in one time step.
  task automatic send_status(input logic [0:7] w1, input logic [0:7] w2);
    statusValid = 1'b1;
    statusWord1 = w1;
    statusWord2 = w2;
    @(posedge ref_clk);
    #1;
    statusValid = 1'b0;
    statusWord1 = ~w1;
    statusWord2 = ~w2;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic send_byte(input logic [7:0] b);
    headerByteValid = 1'b1;
    headerByte = b;
    @(posedge ref_clk);
    #1;
    headerByteValid = 1'b0;
    headerByte = ~b;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

/* tb/disk_err_silo_tb.sv */
// Purpose: Self-checking bench for the error register and silo readout.
// Assumes: Inputs change 1 ns after the rising edge of ref_clk.
// Notes:   The timeout is shortened to keep the run brief.
`timescale 1ns/10ps
module disk_err_silo_tb;
  localparam int TMO = 20;
  logic        ref_clk, rstn, ctrlInit, cmdLoad, cmdDone, sectorSearch;
  logic        crcFail, crcInHeader, siloEmpty, siloFull, wcLoad, dmaWord;
  logic        seekComplete, driveErrorPin, driveReadyPin, statusValid;
  logic        headerByteValid, iotStrobe, cpuWorkValid, cmdEnd;
  logic [2:0]  cmdFunction;
  logic [11:0] wcValue, iotCode, wordCount;
  logic [0:7]  statusWord1, statusWord2;
  logic [7:0]  headerByte;
  logic [0:11] cpu_work_register;
  logic [7:0]  hb [6];
  int          nFail, checkCount;

  disk_err_silo #(.TIMEOUT_CYCLES(TMO)) u_disk_err_silo (
    .ref_clk(ref_clk), .rstn(rstn), .ctrlInit(ctrlInit), .cmdLoad(cmdLoad),
    .cmdFunction(cmdFunction), .cmdDone(cmdDone),
    .sectorSearch(sectorSearch), .crcFail(crcFail),
    .crcInHeader(crcInHeader), .siloEmpty(siloEmpty), .siloFull(siloFull),
    .wcLoad(wcLoad), .wcValue(wcValue), .dmaWord(dmaWord),
    .seekComplete(seekComplete), .driveErrorPin(driveErrorPin),
    .driveReadyPin(driveReadyPin), .statusValid(statusValid),
    .statusWord1(statusWord1), .statusWord2(statusWord2),
    .headerByteValid(headerByteValid), .headerByte(headerByte),
    .iotStrobe(iotStrobe), .iotCode(iotCode),
    .cpu_work_register(cpu_work_register), .cpuWorkValid(cpuWorkValid),
    .wordCount(wordCount), .cmdEnd(cmdEnd));

  drive_model u_drive_model (
    .ref_clk(ref_clk), .driveErrorPin(driveErrorPin),
    .driveReadyPin(driveReadyPin), .statusValid(statusValid),
    .statusWord1(statusWord1), .statusWord2(statusWord2),
    .headerByteValid(headerByteValid), .headerByte(headerByte));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  // The strobe is dropped for a cycle after each read, so that reads in a
  // row never lower and raise it in one time step.
  task automatic rd(input logic [11:0] code, output logic [0:11] data);
    iotStrobe = 1'b1;
    iotCode = code;
    tick(1);
    iotStrobe = 1'b0;
    check({11'h000, cpuWorkValid}, 12'h001);
    data = cpu_work_register;
    tick(1);
  endtask

  task automatic errChk(input logic [0:2] c, input logic f, input logic r);
    logic [0:11] w;
    rd(disk_err_pkg::READ_ERROR_IOT, w);
    check(w, {c, 7'h00, f, r});
  endtask

  task automatic siloChk(input logic [11:0] exp);
    logic [0:11] w;
    rd(disk_err_pkg::READ_SILO_IOT, w);
    check(w, exp);
  endtask

  task automatic cmd(input logic [2:0] fn);
    cmdFunction = fn;
    pulse(cmdLoad);
    tick(1);
  endtask

  task automatic s_status;
    u_drive_model.set_pins(1'b1, 1'b0);
    tick(4);
    errChk(3'h0, 1'b1, 1'b0);
    u_drive_model.set_pins(1'b0, 1'b1);
    cmd(disk_err_pkg::FN_GET_STATUS);
    u_drive_model.send_status(8'hA5, 8'h3C);
    siloChk({4'h0, 8'hA5});
    siloChk({4'h0, 8'h3C});
    siloChk(12'h000);
    pulse(cmdDone);
  endtask

  task automatic s_header;
    hb = '{8'hC3, 8'h5A, 8'hFF, 8'h96, 8'h0F, 8'hE1};
    cmd(disk_err_pkg::FN_READ_HEADER);
    for (int i = 0; i < 6; i++) u_drive_model.send_byte(hb[i]);
    pulse(cmdDone);
    for (int i = 0; i < 6; i++) begin
      siloChk((i == 2 || i == 3) ? 12'h000 : {4'h0, hb[i]});
    end
  endtask

  // Write watches an empty silo, both read modes a full one.
  task automatic s_late;
    for (int f = 5; f < 8; f++) begin
      wcValue = 12'hFFC;
      pulse(wcLoad);
      cmd(f[2:0]);
      if (f == 5) pulse(siloEmpty);
      else pulse(siloFull);
      tick(2);
      errChk(disk_err_pkg::CODE_DATA_LATE, 1'b0, 1'b1);
      cmd(disk_err_pkg::FN_GET_STATUS);
      errChk(disk_err_pkg::CODE_RESET, 1'b0, 1'b1);
      pulse(ctrlInit);
    end
  endtask

  task automatic s_crc;
    cmd(disk_err_pkg::FN_READ_DATA);
    pulse(crcFail);
    tick(1);
    errChk(disk_err_pkg::CODE_DATA_CRC, 1'b0, 1'b1);
    cmd(disk_err_pkg::FN_READ_HEADER);
    crcInHeader = 1'b1;
    pulse(crcFail);
    crcInHeader = 1'b0;
    tick(1);
    errChk(disk_err_pkg::CODE_HDR_CRC, 1'b0, 1'b1);
    pulse(ctrlInit);
  endtask

  task automatic s_timeout;
    cmd(disk_err_pkg::FN_WRITE_DATA);
    tick(TMO - 6);
    errChk(disk_err_pkg::CODE_RESET, 1'b0, 1'b1);
    tick(8);
    errChk(disk_err_pkg::CODE_OP_INCOMP, 1'b0, 1'b1);
    sectorSearch = 1'b1;
    cmd(disk_err_pkg::FN_READ_DATA);
    tick(TMO + 3);
    errChk(disk_err_pkg::CODE_HDR_MISS, 1'b0, 1'b1);
    sectorSearch = 1'b0;
    cmd(disk_err_pkg::FN_WRITE_DATA);
    pulse(cmdDone);
    tick(TMO + 3);
    errChk(disk_err_pkg::CODE_RESET, 1'b0, 1'b1);
    pulse(ctrlInit);
  endtask

  task automatic s_seek_wc;
    cmd(disk_err_pkg::FN_SEEK);
    errChk(disk_err_pkg::CODE_RESET, 1'b0, 1'b0);
    pulse(seekComplete);
    tick(2);
    errChk(disk_err_pkg::CODE_RESET, 1'b0, 1'b1);
    pulse(ctrlInit);
    wcValue = 12'hFFE;
    pulse(wcLoad);
    dmaWord = 1'b1;
    tick(1);
    check(wordCount, 12'hFFF);
    tick(1);
    dmaWord = 1'b0;
    check({cmdEnd, wordCount[10:0]}, 12'h800);
    tick(1);
    check({11'h000, cmdEnd}, 12'h000);
  endtask

  initial begin
    {rstn, ctrlInit, cmdLoad, cmdDone, sectorSearch, crcFail} = 6'h00;
    {crcInHeader, siloEmpty, siloFull, wcLoad, dmaWord} = 5'h00;
    {seekComplete, iotStrobe} = 2'h0;
    {cmdFunction, wcValue, iotCode} = 27'h0000000;
    {nFail, checkCount} = 64'h0;
    tick(4);
    rstn = 1'b1;
    tick(3);
    errChk(disk_err_pkg::CODE_RESET, 1'b0, 1'b1);
    s_status();
    s_header();
    s_late();
    s_crc();
    s_timeout();
    s_seek_wc();
    close_out();
  end

  initial begin
    #1000000;
    nFail++;
    close_out();
  end
endmodule
